// [ser_cfg.svh]
`ifndef SER_CFG_SVH
`define SER_CFG_SVH

// register byte offsets on the APB port
`define SER_REG_CTRL      8'h00
`define SER_REG_TRIG_EXP  8'h04
`define SER_REG_CMD       8'h08
`define SER_REG_ERRQ      8'h0C
`define SER_REG_STATUS    8'h10
`define SER_REG_ACQ_CNT   8'h14

// control register fields
`define SER_CTRL_TRIG_EN  0
`define SER_CTRL_SRC_LO   1
`define SER_CTRL_SRC_HI   2
`define SER_CTRL_CLEARING 3

// status register fields
`define SER_ST_SLEEP      0
`define SER_ST_RESP       1
`define SER_ST_QOVF       2
`define SER_ST_CONT       3
`define SER_ST_IDN        4
`define SER_ST_RCV_LO     16

// reset value and default number of ranges
`define SER_TRIG_EXP_RST  16'h0001
`define SER_NUM_RANGES    4

// numeric limits
`define SER_EXP_MAX       6'h2B
`define SER_DELTA_MAX     17'h0_007F
`define SER_DELTA_MIN     17'h1_FF80

// error codes, 16-bit two's complement
`define SER_E_NONE        16'h0000
`define SER_E_SYNTAX      16'hFF9A
`define SER_E_DTYPE       16'hFF98
`define SER_E_NPARAM      16'hFF8D
`define SER_E_EXPONENT    16'hFF85
`define SER_E_STRING      16'hFF69
`define SER_E_EXPR        16'hFF55
`define SER_E_CONFLICT    16'hFF23
`define SER_E_RANGE       16'hFF22
`define SER_E_MEMORY      16'hFF1F
`define SER_E_QUERY       16'hFE70
`define SER_E_QINTR       16'hFE66
`define SER_E_QUNTERM     16'hFE5C
`define SER_E_QINDEF      16'hFE48
`define SER_E_LIST        16'h0065
`define SER_E_UNITS       16'h0067
`define SER_E_OVERRUN     16'h00CC
`define SER_E_OVERRANGE   16'h00CD
`define SER_E_TIMER       16'h00CE
`define SER_E_DELTA       16'h00CF

`endif

// [ser_pkg.sv]
package ser_pkg;

	typedef enum logic [1:0] {
		SER_SRC_IMMED = 2'b00,
		SER_SRC_BUS   = 2'b01,
		SER_SRC_TIMER = 2'b10,
		SER_SRC_RSVD  = 2'b11
	} ser_src_t;

	typedef enum logic [3:0] {
		SER_OP_NONE      = 4'b0000,
		SER_OP_START_ACQ = 4'b0001,
		SER_OP_BUS_TRIG  = 4'b0010,
		SER_OP_CALIB     = 4'b0011,
		SER_OP_FETCH     = 4'b0100,
		SER_OP_INIT_ALL  = 4'b0101,
		SER_OP_READ      = 4'b0110,
		SER_OP_RANGE_SEL = 4'b0111,
		SER_OP_INIT_CONT = 4'b1000,
		SER_OP_SLEEP     = 4'b1001,
		SER_OP_STORE     = 4'b1010,
		SER_OP_IDN       = 4'b1011,
		SER_OP_RESP_READ = 4'b1100,
		SER_OP_RESP_DONE = 4'b1101,
		SER_OP_GENERIC   = 4'b1110,
		SER_OP_RSVD      = 4'b1111
	} ser_op_t;

	// command descriptor written by the parser firmware
	typedef struct packed {
		logic [7:0] arg;
		logic [5:0] exp_mag;
		logic       fmt_len_bad;
		logic       flash_full;
		logic       msg_end;
		logic       is_query;
		logic       range_bad;
		logic       units_bad;
		logic       list_bad;
		logic       bracket_bad;
		logic       quote_bad;
		logic       count_bad;
		logic       type_bad;
		logic       hdr_bad;
		logic [1:0] rsvd;
		ser_op_t    op;
	} ser_cmd_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        trig_en;
		ser_src_t    src;
		logic        clearing;
		logic [15:0] trig_exp;
		logic [15:0] trig_rcv;
		logic [15:0] acq_cnt;
		logic        sleep;
		logic        cont;
		logic        resp_pend;
		logic        idn_open;
		logic        pend_ovr;
		logic        pend_rng;
		logic        pend_tmr;
		logic        pend_dlt;
		logic        q_ovf;
		logic        err_pend;
		logic [15:0] recon;
		logic [7:0]  delta;
		logic        delta_valid;
		logic        skip;
	} ser_state_t;

endpackage

// [ser_errq_if.sv]
`timescale 1ns/1ns
interface ser_errq_if #(
	parameter int W     = 16,
	parameter int DEPTH = 16
);
	localparam int CW = $clog2(DEPTH) + 1;

	logic          push;
	logic [W-1:0]  push_code;
	logic          pop;
	logic [W-1:0]  head;
	logic          empty;
	logic          full;
	logic [CW-1:0] count;

	modport producer (output push, output push_code, output pop,
		input head, input empty, input full, input count);
	modport queue (input push, input push_code, input pop,
		output head, output empty, output full, output count);
endinterface

// [ser_err_fifo.sv]
`timescale 1ns/1ns
module ser_err_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 16
) (
	input  wire logic CORE_CLK,
	input  wire logic SYS_RST,
	ser_errq_if.queue q
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	// pointers wrap by overflow, so only powers of two are served
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("ser_err_fifo: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           rd_ptr;
		logic [AW-1:0]           wr_ptr;
		logic [CW-1:0]           count;
	} ser_fifo_state_t;

	ser_fifo_state_t s_q;
	ser_fifo_state_t s_d;
	logic            do_push;
	logic            do_pop;

	assign q.head  = s_q.mem[s_q.rd_ptr];
	assign q.empty = (s_q.count == '0);
	assign q.full  = (s_q.count == CW'(DEPTH));
	assign q.count = s_q.count;

	always_comb begin
		s_d = s_q;
		do_pop = q.pop && !q.empty;
		// a full queue drops the newest code, oldest ones survive
		do_push = q.push && (!q.full || do_pop);
		if (do_push) begin
			s_d.mem[s_q.wr_ptr] = q.push_code;
			s_d.wr_ptr = s_q.wr_ptr + AW'(1);
		end
		if (do_pop) begin
			s_d.rd_ptr = s_q.rd_ptr + AW'(1);
		end
		s_d.count = s_q.count + CW'(do_push) - CW'(do_pop);
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// [ser_error_reporter.sv]
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "ser_cfg.svh"

module ser_error_reporter
	import ser_pkg::*;
#(
	parameter int QDEPTH     = 16,
	parameter int NUM_RANGES = `SER_NUM_RANGES
) (
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        EVT_OVERRUN,
	input  wire logic        EVT_OVERRANGE,
	input  wire logic        EVT_TIMER,
	input  wire logic        MEAS_BUSY,
	input  wire logic        SAMPLE_VALID,
	input  wire logic [15:0] SAMPLE,
	output logic      [7:0]  DELTA_OUT,
	output logic             DELTA_VALID,
	output logic             SKIP_NEXT,
	output logic             SLEEP_ACTIVE,
	output logic             ERR_PENDING
);
	if (NUM_RANGES < 1 || NUM_RANGES > 256) begin : g_chk
		$error("ser_error_reporter: NUM_RANGES must be 1..256");
	end

	localparam logic [8:0] RANGES = 9'(NUM_RANGES);

	ser_errq_if #(.W(16), .DEPTH(QDEPTH)) errq ();

	ser_err_fifo #(
		.W     (16),
		.DEPTH (QDEPTH)
	) u_fifo (
		.CORE_CLK (CORE_CLK),
		.SYS_RST  (SYS_RST),
		.q        (errq)
	);

	ser_state_t         s_q;
	ser_state_t         s_d;
	ser_cmd_t           cmd;
	logic               setup;
	logic               acc_wr;
	logic               acc_rd;
	logic               cmd_go;
	logic               bus_armed;
	logic [15:0]        code;
	logic signed [16:0] diff;
	logic [7:0]         dclip;
	logic               dbad;

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register

	assign PRDATA       = s_q.prdata;
	assign PREADY       = s_q.pready;
	assign PSLVERR      = s_q.pslverr;
	assign DELTA_OUT    = s_q.delta;
	assign DELTA_VALID  = s_q.delta_valid;
	assign SKIP_NEXT    = s_q.skip;
	assign SLEEP_ACTIVE = s_q.sleep;
	assign ERR_PENDING  = s_q.err_pend;

	assign errq.push      = (code != `SER_E_NONE);
	assign errq.push_code = code;

	////////////////////////////////////////////////////////////////////////
	// delta encoder for packed output

	always_comb begin
		diff = $signed({SAMPLE[15], SAMPLE}) - $signed({s_q.recon[15],
			s_q.recon});
		dclip = diff[7:0];
		dbad = 1'b0;
		// clamp to the widest step, the residual stays in diff next time
		if (diff > $signed(`SER_DELTA_MAX)) begin
			dclip = 8'(`SER_DELTA_MAX);
			dbad = 1'b1;
		end else if (diff < $signed(`SER_DELTA_MIN)) begin
			dclip = 8'(`SER_DELTA_MIN);
			dbad = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register access, command checks and event collection

	always_comb begin
		s_d = s_q;
		s_d.skip = 1'b0;
		s_d.delta_valid = 1'b0;
		code = `SER_E_NONE;
		errq.pop = 1'b0;
		cmd = ser_cmd_t'(PWDATA);
		setup = PSEL && !PENABLE;
		acc_wr = PSEL && PENABLE && s_q.pready && PWRITE;
		acc_rd = PSEL && PENABLE && s_q.pready && !PWRITE;
		cmd_go = acc_wr && (PADDR == `SER_REG_CMD);
		bus_armed = s_q.trig_en && (s_q.src == SER_SRC_BUS);

		// zero-wait slave: ready and read data are loaded in setup
		s_d.pready = setup;
		s_d.pslverr = 1'b0;
		if (setup) begin
			s_d.prdata = '0;
			unique case (PADDR)
				`SER_REG_CTRL: begin
					s_d.prdata[`SER_CTRL_TRIG_EN] = s_q.trig_en;
					s_d.prdata[`SER_CTRL_SRC_HI:`SER_CTRL_SRC_LO] = s_q.src;
					s_d.prdata[`SER_CTRL_CLEARING] = s_q.clearing;
				end
				`SER_REG_TRIG_EXP: s_d.prdata[15:0] = s_q.trig_exp;
				`SER_REG_CMD: s_d.prdata = '0;
				`SER_REG_ERRQ: begin
					if (!errq.empty) begin
						s_d.prdata = {{16{errq.head[15]}}, errq.head};
					end
				end
				`SER_REG_STATUS: begin
					s_d.prdata[`SER_ST_SLEEP] = s_q.sleep;
					s_d.prdata[`SER_ST_RESP] = s_q.resp_pend;
					s_d.prdata[`SER_ST_QOVF] = s_q.q_ovf;
					s_d.prdata[`SER_ST_CONT] = s_q.cont;
					s_d.prdata[`SER_ST_IDN] = s_q.idn_open;
					s_d.prdata[31:`SER_ST_RCV_LO] = s_q.trig_rcv;
				end
				`SER_REG_ACQ_CNT: s_d.prdata[15:0] = s_q.acq_cnt;
				default: s_d.pslverr = 1'b1;
			endcase
		end

		// only a code that the read returned leaves, at its completing edge
		if (acc_rd && PADDR == `SER_REG_ERRQ &&
			s_q.prdata != '0) begin
			errq.pop = 1'b1;
		end

		if (acc_wr && PADDR == `SER_REG_CTRL) begin
			s_d.trig_en = PWDATA[`SER_CTRL_TRIG_EN];
			s_d.src = ser_src_t'(PWDATA[`SER_CTRL_SRC_HI:`SER_CTRL_SRC_LO]);
			s_d.clearing = PWDATA[`SER_CTRL_CLEARING];
			// a fresh arm restarts the trigger tally
			if (PWDATA[`SER_CTRL_TRIG_EN] && !s_q.trig_en) begin
				s_d.trig_rcv = '0;
			end
			if (!PWDATA[`SER_CTRL_TRIG_EN]) begin
				s_d.cont = 1'b0;
			end
		end
		if (acc_wr && PADDR == `SER_REG_TRIG_EXP) begin
			s_d.trig_exp = PWDATA[15:0];
		end
		if (acc_wr && PADDR == `SER_REG_STATUS && PWDATA[`SER_ST_QOVF]) begin
			s_d.q_ovf = 1'b0;
		end

		if (cmd_go) begin
			// a new command abandons an unread response
			if (s_q.resp_pend && cmd.op != SER_OP_RESP_READ &&
				cmd.op != SER_OP_RESP_DONE) begin
				code = `SER_E_QINTR;
				s_d.resp_pend = 1'b0;
			end else if (cmd.op == SER_OP_RESP_READ) begin
				if (!s_q.resp_pend) begin
					code = `SER_E_QUNTERM;
				end
			end else if (cmd.op == SER_OP_RESP_DONE) begin
				s_d.resp_pend = 1'b0;
			end else if (cmd.hdr_bad) begin
				code = `SER_E_SYNTAX;
			end else if (cmd.type_bad) begin
				code = `SER_E_DTYPE;
			end else if (cmd.count_bad) begin
				code = `SER_E_NPARAM;
			end else if (cmd.exp_mag > `SER_EXP_MAX) begin
				code = `SER_E_EXPONENT;
			end else if (cmd.quote_bad) begin
				code = `SER_E_STRING;
			end else if (cmd.bracket_bad) begin
				code = `SER_E_EXPR;
			end else if (cmd.list_bad) begin
				code = `SER_E_LIST;
			end else if (cmd.units_bad) begin
				code = `SER_E_UNITS;
			end else if (cmd.is_query && s_q.clearing) begin
				code = `SER_E_QUERY;
			end else if (cmd.is_query && s_q.idn_open) begin
				code = `SER_E_QINDEF;
			end else begin
				unique case (cmd.op)
					SER_OP_START_ACQ: begin
						if (!s_q.trig_en) begin
							code = `SER_E_CONFLICT;
						end else begin
							s_d.acq_cnt = '0;
							s_d.recon = '0;
						end
					end
					SER_OP_BUS_TRIG: begin
						if (!bus_armed || s_q.trig_rcv >= s_q.trig_exp) begin
							code = `SER_E_CONFLICT;
						end else begin
							s_d.trig_rcv = s_q.trig_rcv + 16'h0001;
						end
					end
					SER_OP_CALIB, SER_OP_INIT_ALL: begin
						if (bus_armed) begin
							code = `SER_E_CONFLICT;
						end
					end
					SER_OP_FETCH, SER_OP_READ: begin
						if (bus_armed) begin
							code = `SER_E_CONFLICT;
						end else if (cmd.range_bad ||
							{8'h00, cmd.arg} > s_q.acq_cnt) begin
							code = `SER_E_RANGE;
						end
					end
					SER_OP_RANGE_SEL: begin
						if (bus_armed) begin
							code = `SER_E_CONFLICT;
						end else if (cmd.range_bad ||
							{1'b0, cmd.arg} >= RANGES) begin
							code = `SER_E_RANGE;
						end
					end
					SER_OP_INIT_CONT: begin
						if (s_q.src == SER_SRC_IMMED) begin
							code = `SER_E_CONFLICT;
						end else begin
							s_d.cont = 1'b1;
						end
					end
					SER_OP_SLEEP: begin
						if (s_q.trig_en) begin
							code = `SER_E_CONFLICT;
						end else begin
							s_d.sleep = 1'b1;
						end
					end
					SER_OP_STORE: begin
						if (cmd.range_bad) begin
							code = `SER_E_RANGE;
						end else if (cmd.flash_full) begin
							code = `SER_E_MEMORY;
						end
					end
					default: begin
						if (cmd.range_bad || cmd.fmt_len_bad) begin
							code = `SER_E_RANGE;
						end
					end
				endcase
			end

			// any accepted command except SER_OP_NONE and SER_OP_SLEEP wakes a sleeping instrument
			if (cmd.op != SER_OP_SLEEP && cmd.op != SER_OP_NONE) begin
				s_d.sleep = (code != `SER_E_NONE) && s_q.sleep;
			end
			if (code == `SER_E_NONE && cmd.is_query) begin
				s_d.resp_pend = 1'b1;
				if (cmd.op == SER_OP_IDN) begin
					s_d.idn_open = 1'b1;
				end
			end
			// the indefinite response window ends with its message
			if (cmd.msg_end) begin
				s_d.idn_open = 1'b0;
			end
		end

		// acquisition events wait while a command code takes the slot;
		// drained before new sets so an arriving event wins
		if (code == `SER_E_NONE) begin
			if (s_q.pend_ovr) begin
				code = `SER_E_OVERRUN;
				s_d.pend_ovr = 1'b0;
			end else if (s_q.pend_rng) begin
				code = `SER_E_OVERRANGE;
				s_d.pend_rng = 1'b0;
			end else if (s_q.pend_tmr) begin
				code = `SER_E_TIMER;
				s_d.pend_tmr = 1'b0;
			end else if (s_q.pend_dlt) begin
				code = `SER_E_DELTA;
				s_d.pend_dlt = 1'b0;
			end
		end

		if (EVT_OVERRUN && s_q.src == SER_SRC_TIMER) begin
			s_d.pend_ovr = 1'b1;
		end
		if (EVT_OVERRANGE) begin
			s_d.pend_rng = 1'b1;
		end
		if (EVT_TIMER && MEAS_BUSY && s_q.src == SER_SRC_TIMER) begin
			s_d.pend_tmr = 1'b1;
			s_d.skip = 1'b1;
		end

		if (SAMPLE_VALID) begin
			s_d.delta = dclip;
			s_d.delta_valid = 1'b1;
			s_d.recon = s_q.recon + {{8{dclip[7]}}, dclip};
			if (s_q.acq_cnt != 16'hFFFF) begin
				s_d.acq_cnt = s_q.acq_cnt + 16'h0001;
			end
			if (dbad) begin
				s_d.pend_dlt = 1'b1;
			end
		end

		if (errq.push && errq.full && !errq.pop) begin
			s_d.q_ovf = 1'b1;
		end
		s_d.err_pend = !(errq.empty && !errq.push) &&
			!(errq.count == 1 && errq.pop && !errq.push);
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			s_q <= '0;
			s_q.trig_exp <= `SER_TRIG_EXP_RST;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// [ser_error_reporter_properties.sv]
`timescale 1ns/1ns
module ser_error_reporter_properties
	import ser_pkg::*;
(
	input wire logic        CORE_CLK,
	input wire logic        SYS_RST,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        EVT_OVERRANGE,
	input wire logic        EVT_TIMER,
	input wire logic        MEAS_BUSY,
	input wire logic        SAMPLE_VALID,
	input wire logic [7:0]  DELTA_OUT,
	input wire logic        DELTA_VALID,
	input wire logic        SKIP_NEXT,
	input wire logic        SLEEP_ACTIVE,
	input wire logic        ERR_PENDING
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (SYS_RST);

	logic pop;
	logic cmdw;

	assign pop  = PSEL && PENABLE && PREADY && !PWRITE && PADDR == 8'h0C;
	assign cmdw = PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h08;

	////////////////////////////////////////////////////////////////////
	AST_READY_AFTER_SETUP: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("ready missing after setup");
	AST_READY_ONE_CYCLE: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	AST_SLVERR_UNMAPPED: assert property (PSLVERR |-> PREADY && PADDR > 8'h14)
		else $error("slave error on mapped register");
	AST_HDR_QUEUED: assert property (cmdw && PWDATA[6] |-> ##[1:3] ERR_PENDING)
		else $error("bad header left queue empty");
	AST_RANGE_EVT_QUEUED: assert property (EVT_OVERRANGE |-> ##[1:4] ERR_PENDING)
		else $error("over-range event not queued");
	AST_SKIP_CAUSE: assert property (SKIP_NEXT |-> $past(EVT_TIMER && MEAS_BUSY))
		else $error("skip without busy timer expiry");
	AST_DELTA_FOLLOWS: assert property (SAMPLE_VALID |=> DELTA_VALID)
		else $error("sample produced no delta");
	AST_DELTA_CAUSE: assert property (DELTA_VALID |-> $past(SAMPLE_VALID))
		else $error("delta without sample");
	AST_PEND_CLEARS: assert property ($fell(ERR_PENDING) |-> $past(pop)
		|| $past(pop, 2) || $past(SYS_RST) || $past(SYS_RST, 2))
		else $error("pending flag fell without pop");
	AST_SLEEP_CAUSE: assert property ($rose(SLEEP_ACTIVE)
		|-> $past(cmdw && PWDATA[3:0] == SER_OP_SLEEP))
		else $error("sleep entered without request");

	COV_CMD: cover property (cmdw && PWDATA[6]);
	COV_SKIP: cover property (SKIP_NEXT);
	COV_CLIP: cover property (DELTA_VALID && DELTA_OUT == 8'h7F);
endmodule

bind ser_error_reporter ser_error_reporter_properties u_props (
	.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .EVT_OVERRANGE(EVT_OVERRANGE),
	.EVT_TIMER(EVT_TIMER), .MEAS_BUSY(MEAS_BUSY),
	.SAMPLE_VALID(SAMPLE_VALID), .DELTA_OUT(DELTA_OUT),
	.DELTA_VALID(DELTA_VALID), .SKIP_NEXT(SKIP_NEXT),
	.SLEEP_ACTIVE(SLEEP_ACTIVE), .ERR_PENDING(ERR_PENDING)
);

// [ser_host_model.sv]
`timescale 1ns/1ns
`include "ser_cfg.svh"
module ser_host_model (
	input  wire logic        clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// call just after a rising edge; ends one idle cycle after release
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines must not look like a held request
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge clk);
	endtask

	// well-behaved query: sent whole, answer read, then finished
	task automatic query(input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		xfer(1'b1, `SER_REG_CMD, d, r, e);
		xfer(1'b1, `SER_REG_CMD, 32'h0000_000C, r, e);
		xfer(1'b1, `SER_REG_CMD, 32'h0000_000D, r, e);
	endtask
endmodule

// [ser_error_reporter_bench.sv]
`timescale 1ns/1ns
`include "ser_cfg.svh"
module ser_error_reporter_bench
	import ser_pkg::*;
();
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, dout;
	logic [31:0] pwdata, prdata;
	logic [2:0]  ev = 3'h0;
	logic        busy = 1'b0;
	logic        sv = 1'b0;
	logic [15:0] smp = 16'h0000;
	logic        dval, skip, slp, pend, sk;
	int          failures = 0;
	int          compares = 0;
	int          cycles = 0;
	int          seed = 32'h2771_064e;
	int          bits[9] = '{6, 7, 8, 9, 10, 11, 12, 13, 17};

	always #5 clk = ~clk;

	ser_host_model u_host (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	ser_error_reporter u_dut (.CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.EVT_OVERRUN(ev[0]), .EVT_OVERRANGE(ev[1]), .EVT_TIMER(ev[2]),
		.MEAS_BUSY(busy), .SAMPLE_VALID(sv), .SAMPLE(smp), .DELTA_OUT(dout),
		.DELTA_VALID(dval), .SKIP_NEXT(skip), .SLEEP_ACTIVE(slp),
		.ERR_PENDING(pend));

	////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// sized generously: the full sequence needs well under 3000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			conclude();
		end
	end

	function automatic logic [31:0] sx(input logic [15:0] c);
		return {{16{c[15]}}, c};
	endfunction

	function automatic logic [31:0] op(input ser_op_t o, input logic [31:0] f);
		return {28'h000_0000, o} | f;
	endfunction

	function automatic logic [15:0] flag_code(input int b);
		case (b)
			6: return `SER_E_SYNTAX;
			7: return `SER_E_DTYPE;
			8: return `SER_E_NPARAM;
			9: return `SER_E_STRING;
			10: return `SER_E_EXPR;
			11: return `SER_E_LIST;
			12: return `SER_E_UNITS;
			default: return `SER_E_RANGE;
		endcase
	endfunction

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		u_host.xfer(1'b0, a, 32'h0000_0000, r, e);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		u_host.xfer(1'b1, a, d, r, e);
	endtask

	task automatic expq(input logic [15:0] c);
		logic [31:0] r;
		rd(`SER_REG_ERRQ, r);
		check(r, sx(c));
	endtask

	task automatic cmd(input logic [31:0] d, input logic [15:0] c);
		wr(`SER_REG_CMD, d);
		expq(c);
		expq(`SER_E_NONE);
	endtask

	task automatic pulse(input logic [2:0] v);
		ev <= v;
		sk = 1'b0;
		@(posedge clk);
		ev <= 3'h0;
		repeat (4) begin
			@(posedge clk);
			sk = sk | skip;
		end
	endtask

	task automatic samp(input logic [15:0] v, input logic [7:0] dx);
		smp <= v;
		sv <= 1'b1;
		@(posedge clk);
		sv <= 1'b0;
		#1;
		check({23'h00_0000, dval, dout}, {24'h00_0001, dx});
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] r;
		logic        e;
		int          b, s, p;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(`SER_REG_TRIG_EXP, r);
		check(r, 32'h0000_0001);
		rd(`SER_REG_CMD, r);
		check(r, 32'h0000_0000);
		u_host.xfer(1'b0, 8'h1C, 32'h0000_0000, r, e);
		check({e, r[30:0]}, 32'h8000_0000);
		foreach (bits[i])
			cmd(op(SER_OP_GENERIC, 32'h1 << bits[i]), flag_code(bits[i]));
		repeat (12) begin
			b = bits[$unsigned($random(seed)) % 9];
			p = $unsigned($random(seed)) % 44;
			r = $random(seed);
			cmd(op(SER_OP_GENERIC, (32'h1 << b) | (p << 18) | {r[7:0], 24'h0}),
				flag_code(b));
		end
		cmd(op(SER_OP_GENERIC, 32'h0000_002B << 18), `SER_E_NONE);
		cmd(op(SER_OP_GENERIC, 32'h0000_002C << 18), `SER_E_EXPONENT);
		wr(`SER_REG_CMD, op(SER_OP_GENERIC, 32'h0000_0040));
		wr(`SER_REG_CMD, op(SER_OP_GENERIC, 32'h0000_1000));
		expq(`SER_E_SYNTAX);
		cmd(op(SER_OP_NONE, 32'h0), `SER_E_UNITS);
		cmd(op(SER_OP_START_ACQ, 32'h0), `SER_E_CONFLICT);
		cmd(op(SER_OP_BUS_TRIG, 32'h0), `SER_E_CONFLICT);
		wr(`SER_REG_CTRL, 32'h0000_0001);
		cmd(op(SER_OP_BUS_TRIG, 32'h0), `SER_E_CONFLICT);
		cmd(op(SER_OP_INIT_CONT, 32'h0), `SER_E_CONFLICT);
		cmd(op(SER_OP_SLEEP, 32'h0), `SER_E_CONFLICT);
		wr(`SER_REG_CTRL, 32'h0000_0003);
		cmd(op(SER_OP_BUS_TRIG, 32'h0), `SER_E_NONE);
		cmd(op(SER_OP_BUS_TRIG, 32'h0), `SER_E_CONFLICT);
		for (b = 3; b < 8; b++)
			cmd(op(ser_op_t'(b), 32'h0), `SER_E_CONFLICT);
		wr(`SER_REG_CTRL, 32'h0000_0001);
		cmd(op(SER_OP_RANGE_SEL, 32'h0300_0000), `SER_E_NONE);
		cmd(op(SER_OP_RANGE_SEL, 32'h0400_0000), `SER_E_RANGE);
		cmd(op(SER_OP_STORE, 32'h0001_0000), `SER_E_MEMORY);
		wr(`SER_REG_CTRL, 32'h0000_0008);
		cmd(op(SER_OP_GENERIC, 32'h0000_C000), `SER_E_QUERY);
		wr(`SER_REG_CTRL, 32'h0000_0001);
		cmd(op(SER_OP_GENERIC, 32'h0000_C000), `SER_E_NONE);
		cmd(op(SER_OP_NONE, 32'h0), `SER_E_QINTR);
		cmd(op(SER_OP_RESP_READ, 32'h0), `SER_E_QUNTERM);
		u_host.query(op(SER_OP_IDN, 32'h0000_4000));
		repeat (3) rd(`SER_REG_ERRQ, r);
		cmd(op(SER_OP_GENERIC, 32'h0000_4000), `SER_E_QINDEF);
		wr(`SER_REG_CMD, op(SER_OP_NONE, 32'h0000_8000));
		repeat (3) rd(`SER_REG_ERRQ, r);
		pulse(3'b001);
		expq(`SER_E_NONE);
		pulse(3'b010);
		expq(`SER_E_OVERRANGE);
		wr(`SER_REG_CTRL, 32'h0000_0005);
		pulse(3'b001);
		expq(`SER_E_OVERRUN);
		pulse(3'b100);
		check({31'h0, sk}, 32'h0);
		busy <= 1'b1;
		pulse(3'b100);
		busy <= 1'b0;
		check({31'h0, sk}, 32'h1);
		expq(`SER_E_TIMER);
		wr(`SER_REG_CTRL, 32'h0000_0001);
		cmd(op(SER_OP_START_ACQ, 32'h0), `SER_E_NONE);
		samp(16'h000A, 8'h0A);
		samp(16'h012C, 8'h7F);
		samp(16'h012C, 8'h7F);
		samp(16'h012C, 8'h24);
		expq(`SER_E_DELTA);
		expq(`SER_E_DELTA);
		p = 300;
		repeat (5) begin
			s = p + $random(seed) % 50;
			samp(16'(s), 8'(s - p));
			p = s;
		end
		expq(`SER_E_NONE);
		rd(`SER_REG_ACQ_CNT, r);
		check(r, 32'h0000_0009);
		cmd(op(SER_OP_FETCH, 32'h0900_0000), `SER_E_NONE);
		cmd(op(SER_OP_FETCH, 32'h0A00_0000), `SER_E_RANGE);
		repeat (16) wr(`SER_REG_CMD, op(SER_OP_GENERIC, 32'h0000_0040));
		rd(`SER_REG_STATUS, r);
		check(r, 32'h0000_0000);
		check({31'h0, pend}, 32'h1);
		wr(`SER_REG_CMD, op(SER_OP_GENERIC, 32'h0000_1000));
		rd(`SER_REG_STATUS, r);
		check(r, 32'h0000_0004);
		repeat (16) expq(`SER_E_SYNTAX);
		expq(`SER_E_NONE);
		wr(`SER_REG_STATUS, 32'h0000_0004);
		rd(`SER_REG_STATUS, r);
		check(r, 32'h0000_0000);
		wr(`SER_REG_CTRL, 32'h0000_0000);
		cmd(op(SER_OP_SLEEP, 32'h0), `SER_E_NONE);
		check({31'h0, slp}, 32'h1);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check({30'h0, slp, pend}, 32'h0);
		rd(`SER_REG_TRIG_EXP, r);
		check(r, 32'h0000_0001);
		conclude();
	end
endmodule
